// file: logic/travel_guard_pkg.sv
// constants for the travel-limit and emergency-halt guard
// assumes a 32-bit classic wishbone slave port and a 10 MHz clock
package travel_guard_pkg;

    // bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned POS_W  = 32;

    // register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS       = 8'h00;
    localparam logic [ADDR_W-1:0] PLUS_LIMIT_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] MINUS_LIMIT_OFS= 8'h08;
    localparam logic [ADDR_W-1:0] STATUS_OFS     = 8'h0c;
    localparam logic [ADDR_W-1:0] CMD_POS_OFS    = 8'h10;

    // control field positions
    localparam int unsigned CTRL_SCALE_BIT  = 0;
    localparam int unsigned CTRL_SOFT_EN    = 1;
    localparam int unsigned CTRL_PLUS_NC    = 2;
    localparam int unsigned CTRL_MINUS_NC   = 3;
    localparam int unsigned CTRL_HALT_NC    = 4;
    localparam int unsigned CTRL_SERVO_REQ  = 5;
    localparam int unsigned CTRL_W          = 6;

    // control reset: soft check on, every contact normally closed
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h1e;

    // limit reset values
    localparam logic [POS_W-1:0] PLUS_LIMIT_RESET  = 32'h7fffffff;
    localparam logic [POS_W-1:0] MINUS_LIMIT_RESET = 32'h80000000;

    // status field positions
    localparam int unsigned ST_SOFT_WARN   = 0;
    localparam int unsigned ST_HARD_WARN   = 1;
    localparam int unsigned ST_HALT_ALARM  = 2;
    localparam int unsigned ST_PLUS_ENTRY  = 3;
    localparam int unsigned ST_MINUS_ENTRY = 4;
    localparam int unsigned ST_HARD_PLUS   = 5;
    localparam int unsigned ST_HARD_MINUS  = 6;
    localparam int unsigned ST_SERVO_ON    = 7;
    localparam int unsigned ST_BRAKE       = 8;
    localparam int unsigned ST_ALLOW_PLUS  = 9;
    localparam int unsigned ST_ALLOW_MINUS = 10;

    // synchronised pin positions
    localparam int unsigned PIN_PLUS  = 0;
    localparam int unsigned PIN_MINUS = 1;
    localparam int unsigned PIN_HALT  = 2;
    localparam int unsigned PIN_N     = 3;

    // side that tripped a latch
    typedef enum logic [1:0] {
        SIDE_NONE  = 2'b00,
        SIDE_PLUS  = 2'b01,
        SIDE_MINUS = 2'b10
    } side_e;

endpackage : travel_guard_pkg

// file: logic/pin_sync_if.sv
// carries raw limit and halt pins into the filter and clean levels back
// assumes both ends run on the one system clock
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if;
    import travel_guard_pkg::*;
    logic [PIN_N-1:0] raw;
    logic [PIN_N-1:0] clean;
    modport filter (input raw, output clean);
    modport user   (output raw, input clean);
endinterface : pin_sync_if
`default_nettype wire

// file: logic/pin_sync.sv
// three-stage synchroniser with agreement filter for external contacts
// assumes pins are asynchronous to mclk_i
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    // clock and reset
    input  wire logic  mclk_i,
    input  wire logic  rst_i,
    // pins in, levels out
    pin_sync_if.filter pins
);
    import travel_guard_pkg::*;

    logic [PIN_N-1:0] s1_q, s2_q, s3_q, lvl_q;
    logic [PIN_N-1:0] lvl_d;

    // a level moves only once stages two and three agree
    always_comb begin
        lvl_d = lvl_q;
        for (int i = 0; i < PIN_N; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                lvl_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            // reads closed, the reset polarity: no false trip latches
            s1_q  <= '1;
            s2_q  <= '1;
            s3_q  <= '1;
            lvl_q <= '1;
        end else begin
            s1_q  <= pins.raw;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign pins.clean = lvl_q;

endmodule : pin_sync
`default_nettype wire

// file: logic/travel_limit_estop_guard.sv
// travel-limit and emergency-halt supervision with a wishbone register port
// assumes servo-loop position inputs are on mclk_i; contacts are asynchronous
//
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RULE1: the soft limit is checked on the commanded position, never on the measured one.
// RULE2: the commanded position is the measured position plus the position error.
// RULE3: the soft travel warning rises whenever the commanded position is in the forbidden area.
// RULE4: hard limit inputs are watched even with the servo off, on actual motor position.
// RULE5: a hard limit warning holds until the motor moves back opposite to the entered side.
// RULE6: while a limit is active, moves back out opposite to the entry side stay allowed.
// RULE7: soft entry opens the plus or minus entry indicator, swapped by the scale sense setting.
// RULE8: limit inputs are normally closed by default, so an open input raises the hard warning.
// RULE9: systems needing detection on measured position must wire external limit sensors.
// RULE10: while emergency halt is asserted the alarm rises, servo goes off and brake engages.
// RULE11: the emergency halt alarm clears by itself when the input is released.
// RULE12: the emergency halt input is normally closed by default, so an open input alarms.
// RULE13: the side that tripped the hard latch is recorded to know the releasing direction.
module travel_limit_estop_guard (
    // clock and reset
    input  wire logic                                  mclk_i,
    input  wire logic                                  rst_i,
    // wishbone slave
    input  wire logic                                  cyc_i,
    input  wire logic                                  stb_i,
    input  wire logic                                  we_i,
    input  wire logic [travel_guard_pkg::ADDR_W-1:0]   adr_i,
    input  wire logic [3:0]                            sel_i,
    input  wire logic [travel_guard_pkg::DATA_W-1:0]   dat_i,
    output logic [travel_guard_pkg::DATA_W-1:0]        dat_o,
    output logic                                       ack_o,
    // servo loop positions
    input  wire logic [travel_guard_pkg::POS_W-1:0]    actual_pos_i,
    input  wire logic [travel_guard_pkg::POS_W-1:0]    pos_error_i,
    // contacts
    input  wire logic                                  plus_travel_limit_i,
    input  wire logic                                  minus_travel_limit_i,
    input  wire logic                                  emergency_halt_input_i,
    // status and drive outputs
    output logic                                       soft_travel_warning_o,
    output logic                                       hard_travel_warning_o,
    output logic                                       emergency_halt_alarm_o,
    output logic                                       plus_entry_indicator_o,
    output logic                                       minus_entry_indicator_o,
    output logic                                       servo_enable_o,
    output logic                                       dynamic_brake_o,
    output logic                                       allow_plus_move_o,
    output logic                                       allow_minus_move_o
);
    import travel_guard_pkg::*;

    // signed compare helpers
    function automatic logic at_or_above(input logic [POS_W-1:0] a,
                                         input logic [POS_W-1:0] b);
        at_or_above = $signed(a) >= $signed(b);
    endfunction : at_or_above

    function automatic logic at_or_below(input logic [POS_W-1:0] a,
                                         input logic [POS_W-1:0] b);
        at_or_below = $signed(a) <= $signed(b);
    endfunction : at_or_below

    // byte-lane merge for writes
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                                input logic [DATA_W-1:0] nw,
                                                input logic [3:0]        sel);
        logic [DATA_W-1:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        merge = r;
    endfunction : merge

    // contact filtering
    pin_sync_if pins ();
    assign pins.raw = {emergency_halt_input_i, minus_travel_limit_i,
                       plus_travel_limit_i};

    pin_sync u_pin_sync (
        .mclk_i (mclk_i),
        .rst_i  (rst_i),
        .pins   (pins)
    );

    // register state
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [POS_W-1:0]  plus_lim_q, plus_lim_d;
    logic [POS_W-1:0]  minus_lim_q, minus_lim_d;
    logic              ack_q, ack_d;
    logic [DATA_W-1:0] rdat_q, rdat_d;

    // supervision state
    logic [POS_W-1:0]  cmd_pos_q, cmd_pos_d;
    side_e             soft_side_q, soft_side_d;
    side_e             hard_side_q, hard_side_d;
    logic [POS_W-1:0]  hard_pos_q, hard_pos_d;
    logic              halt_q, halt_d;
    logic              servo_q, servo_d;
    logic              ind_plus_q, ind_plus_d;
    logic              ind_minus_q, ind_minus_d;
    logic              allow_p_q, allow_p_d;
    logic              allow_m_q, allow_m_d;
    logic              soft_w_q, soft_w_d;
    logic              hard_w_q, hard_w_d;

    // contact levels after polarity
    logic plus_hit, minus_hit, halt_hit;
    logic [POS_W-1:0] cmd_now;
    logic             in_plus, in_minus;
    logic [DATA_W-1:0] status_w;

    always_comb begin
        // a normally closed contact trips when it reads open (low)
        plus_hit  = ctrl_q[CTRL_PLUS_NC]  ? ~pins.clean[PIN_PLUS]
                                          :  pins.clean[PIN_PLUS]; // RULE8
        minus_hit = ctrl_q[CTRL_MINUS_NC] ? ~pins.clean[PIN_MINUS]
                                          :  pins.clean[PIN_MINUS]; // RULE8
        halt_hit  = ctrl_q[CTRL_HALT_NC]  ? ~pins.clean[PIN_HALT]
                                          :  pins.clean[PIN_HALT]; // RULE12
        cmd_now   = actual_pos_i + pos_error_i; // RULE2
        // only the command is compared; overshoot of the shaft is ignored
        in_plus   = ctrl_q[CTRL_SOFT_EN]
                    & at_or_above(cmd_now, plus_lim_q); // RULE1
        in_minus  = ctrl_q[CTRL_SOFT_EN]
                    & at_or_below(cmd_now, minus_lim_q); // RULE1
    end

    // supervision next state
    always_comb begin
        cmd_pos_d   = cmd_now;
        soft_side_d = soft_side_q;
        hard_side_d = hard_side_q;
        hard_pos_d  = hard_pos_q;
        // soft warning: entry side kept while inside the area
        if (!in_plus && !in_minus) begin
            soft_side_d = SIDE_NONE;
        end else if (soft_side_q == SIDE_NONE) begin
            // a command jumping across the area counts as entering it
            soft_side_d = in_plus ? SIDE_PLUS : SIDE_MINUS; // RULE3
        end
        // hard latch on the actual position, servo state irrelevant
        if (plus_hit) begin
            hard_side_d = SIDE_PLUS; // RULE4 RULE13
            // furthest point kept: sync delay hides the start of the way back
            if (hard_side_q != SIDE_PLUS
                || at_or_above(actual_pos_i, hard_pos_q)) begin
                hard_pos_d = actual_pos_i;
            end
        end else if (minus_hit) begin
            hard_side_d = SIDE_MINUS; // RULE4 RULE13
            if (hard_side_q != SIDE_MINUS
                || at_or_below(actual_pos_i, hard_pos_q)) begin
                hard_pos_d = actual_pos_i;
            end
        end else begin
            case (hard_side_q)
                SIDE_PLUS: begin
                    // released only by travel back below the furthest latched point
                    if ($signed(actual_pos_i) < $signed(hard_pos_q)) begin
                        hard_side_d = SIDE_NONE; // RULE5
                    end
                end
                SIDE_MINUS: begin
                    if ($signed(actual_pos_i) > $signed(hard_pos_q)) begin
                        hard_side_d = SIDE_NONE; // RULE5
                    end
                end
                default: hard_side_d = SIDE_NONE;
            endcase
        end
        soft_w_d = (soft_side_d != SIDE_NONE); // RULE3
        hard_w_d = (hard_side_d != SIDE_NONE); // RULE5
        // emergency halt follows the input, no separate clear
        halt_d  = halt_hit; // RULE10 RULE11
        servo_d = ctrl_q[CTRL_SERVO_REQ] & ~halt_hit; // RULE10
        // entry indicators swap with the scale sense
        if (ctrl_q[CTRL_SCALE_BIT]) begin
            ind_plus_d  = (soft_side_d == SIDE_MINUS); // RULE7
            ind_minus_d = (soft_side_d == SIDE_PLUS); // RULE7
        end else begin
            ind_plus_d  = (soft_side_d == SIDE_PLUS); // RULE7
            ind_minus_d = (soft_side_d == SIDE_MINUS); // RULE7
        end
        // only the way back out of a limit stays open
        allow_p_d = (soft_side_d != SIDE_PLUS)
                    & (hard_side_d != SIDE_PLUS); // RULE6
        allow_m_d = (soft_side_d != SIDE_MINUS)
                    & (hard_side_d != SIDE_MINUS); // RULE6
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_pos_q   <= '0;
            soft_side_q <= SIDE_NONE;
            hard_side_q <= SIDE_NONE;
            hard_pos_q  <= '0;
            halt_q      <= 1'b1;
            servo_q     <= 1'b0;
            ind_plus_q  <= 1'b0;
            ind_minus_q <= 1'b0;
            allow_p_q   <= 1'b0;
            allow_m_q   <= 1'b0;
            soft_w_q    <= 1'b0;
            hard_w_q    <= 1'b0;
        end else begin
            cmd_pos_q   <= cmd_pos_d;
            soft_side_q <= soft_side_d;
            hard_side_q <= hard_side_d;
            hard_pos_q  <= hard_pos_d;
            halt_q      <= halt_d;
            servo_q     <= servo_d;
            ind_plus_q  <= ind_plus_d;
            ind_minus_q <= ind_minus_d;
            allow_p_q   <= allow_p_d;
            allow_m_q   <= allow_m_d;
            soft_w_q    <= soft_w_d;
            hard_w_q    <= hard_w_d;
        end
    end

    // status word
    always_comb begin
        status_w                 = '0;
        status_w[ST_SOFT_WARN]   = soft_w_q;
        status_w[ST_HARD_WARN]   = hard_w_q;
        status_w[ST_HALT_ALARM]  = halt_q;
        status_w[ST_PLUS_ENTRY]  = ind_plus_q;
        status_w[ST_MINUS_ENTRY] = ind_minus_q;
        status_w[ST_HARD_PLUS]   = (hard_side_q == SIDE_PLUS);
        status_w[ST_HARD_MINUS]  = (hard_side_q == SIDE_MINUS);
        status_w[ST_SERVO_ON]    = servo_q;
        status_w[ST_BRAKE]       = halt_q;
        status_w[ST_ALLOW_PLUS]  = allow_p_q;
        status_w[ST_ALLOW_MINUS] = allow_m_q;
    end

    // bus slave: ack one cycle after the strobe, write at the ack edge
    logic req, wr_now;
    logic [DATA_W-1:0] ctrl_ext, ctrl_new;

    always_comb begin
        req         = cyc_i & stb_i;
        wr_now      = req & we_i & ack_q;
        ack_d       = req & ~ack_q;
        ctrl_ext    = {{(DATA_W-CTRL_W){1'b0}}, ctrl_q};
        ctrl_new    = merge(ctrl_ext, dat_i, sel_i);
        ctrl_d      = ctrl_q;
        plus_lim_d  = plus_lim_q;
        minus_lim_d = minus_lim_q;
        rdat_d      = rdat_q;
        if (wr_now) begin
            case (adr_i)
                CTRL_OFS:        ctrl_d = ctrl_new[CTRL_W-1:0];
                PLUS_LIMIT_OFS:  plus_lim_d  = merge(plus_lim_q, dat_i, sel_i);
                MINUS_LIMIT_OFS: minus_lim_d = merge(minus_lim_q, dat_i,
                                                     sel_i);
                default: ;
            endcase
        end
        if (ack_d) begin
            // unmapped offsets read back zero; write cycles load the addressed value too
            case (adr_i)
                CTRL_OFS:        rdat_d = ctrl_ext;
                PLUS_LIMIT_OFS:  rdat_d = plus_lim_q;
                MINUS_LIMIT_OFS: rdat_d = minus_lim_q;
                STATUS_OFS:      rdat_d = status_w;
                CMD_POS_OFS:     rdat_d = cmd_pos_q;
                default:         rdat_d = '0;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q      <= CTRL_RESET;
            plus_lim_q  <= PLUS_LIMIT_RESET;
            minus_lim_q <= MINUS_LIMIT_RESET;
            ack_q       <= 1'b0;
            rdat_q      <= '0;
        end else begin
            ctrl_q      <= ctrl_d;
            plus_lim_q  <= plus_lim_d;
            minus_lim_q <= minus_lim_d;
            ack_q       <= ack_d;
            rdat_q      <= rdat_d;
        end
    end

    // outputs straight from flops
    assign dat_o                   = rdat_q;
    assign ack_o                   = ack_q;
    assign soft_travel_warning_o   = soft_w_q;
    assign hard_travel_warning_o   = hard_w_q;
    assign emergency_halt_alarm_o  = halt_q;
    assign plus_entry_indicator_o  = ind_plus_q;
    assign minus_entry_indicator_o = ind_minus_q;
    assign servo_enable_o          = servo_q;
    assign dynamic_brake_o         = halt_q;
    assign allow_plus_move_o       = allow_p_q;
    assign allow_minus_move_o      = allow_m_q;

endmodule : travel_limit_estop_guard
`default_nettype wire

// file: dv/travel_guard_chk.sv
// port assertions for the travel-limit and emergency-halt guard
// assumes default contact polarity whenever a contact pin changes
`timescale 1ns/1ps
`default_nettype none
module travel_guard_chk (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // bus handshake
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    // contacts
    input wire logic plus_travel_limit_i,
    input wire logic minus_travel_limit_i,
    input wire logic emergency_halt_input_i,
    // status and drive
    input wire logic soft_travel_warning_o,
    input wire logic hard_travel_warning_o,
    input wire logic emergency_halt_alarm_o,
    input wire logic plus_entry_indicator_o,
    input wire logic minus_entry_indicator_o,
    input wire logic servo_enable_o,
    input wire logic dynamic_brake_o,
    input wire logic allow_plus_move_o,
    input wire logic allow_minus_move_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // saturating counts: time since reset, cycles each limit pin open
    logic [4:0] up_q, up_d, plo_q, plo_d, mlo_q, mlo_d;
    always_comb begin
        up_d  = up_q + {4'h0, ~&up_q};
        plo_d = plus_travel_limit_i ? 5'h00 : plo_q + {4'h0, ~&plo_q};
        mlo_d = minus_travel_limit_i ? 5'h00 : mlo_q + {4'h0, ~&mlo_q};
    end
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            up_q  <= 5'h00;
            plo_q <= 5'h00;
            mlo_q <= 5'h00;
        end else begin
            up_q  <= up_d;
            plo_q <= plo_d;
            mlo_q <= mlo_d;
        end
    end
    property p_ack_resp;
        cyc_i && stb_i && !ack_o |=> ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("no ack");
    property p_ack_pulse;
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("long ack");
    property p_brake;
        dynamic_brake_o == emergency_halt_alarm_o;
    endproperty
    a_brake: assert property (p_brake) else $error("brake off");
    property p_servo_off;
        emergency_halt_alarm_o |-> !servo_enable_o;
    endproperty
    a_servo_off: assert property (p_servo_off) else $error("servo on");
    property p_halt_set;
        $fell(emergency_halt_input_i) |-> ##[2:8] emergency_halt_alarm_o;
    endproperty
    a_halt_set: assert property (p_halt_set) else $error("no alarm");
    property p_halt_clr;
        $rose(emergency_halt_input_i) |-> ##[2:8] !emergency_halt_alarm_o;
    endproperty
    a_halt_clr: assert property (p_halt_clr) else $error("alarm held");
    property p_hard_set;
        $fell(plus_travel_limit_i) || $fell(minus_travel_limit_i)
            |-> ##[2:8] hard_travel_warning_o;
    endproperty
    a_hard_set: assert property (p_hard_set) else $error("no hard");
    property p_hard_hold;
        hard_travel_warning_o && (plo_q >= 5'd8 || mlo_q >= 5'd8)
            |=> hard_travel_warning_o;
    endproperty
    a_hard_hold: assert property (p_hard_hold) else $error("hard lost");
    property p_ind;
        plus_entry_indicator_o || minus_entry_indicator_o |->
            soft_travel_warning_o
            && !(plus_entry_indicator_o && minus_entry_indicator_o);
    endproperty
    a_ind: assert property (p_ind) else $error("bad indicator");
    property p_allow;
        up_q >= 5'd16 && hard_travel_warning_o && servo_enable_o
            |-> allow_plus_move_o || allow_minus_move_o;
    endproperty
    a_allow: assert property (p_allow) else $error("no way out");
endmodule : travel_guard_chk
bind travel_limit_estop_guard travel_guard_chk chk_i (.mclk_i, .rst_i,
    .cyc_i, .stb_i, .ack_o, .plus_travel_limit_i, .minus_travel_limit_i,
    .emergency_halt_input_i, .soft_travel_warning_o, .hard_travel_warning_o,
    .emergency_halt_alarm_o, .plus_entry_indicator_o,
    .minus_entry_indicator_o, .servo_enable_o, .dynamic_brake_o,
    .allow_plus_move_o, .allow_minus_move_o);
`default_nettype wire

// file: dv/travel_sensor_model.sv
// limit switches at fixed positions plus a halt switch, closed = 1
// assumes the actual position is on the bench clock
`timescale 1ns/1ps
`default_nettype none
module travel_sensor_model #(
    parameter int PLUS_AT  = 5000,
    parameter int MINUS_AT = -5000
) (
    input  wire logic        mclk_i,
    input  wire logic [31:0] pos_i,
    input  wire logic        press_i,
    output logic             plus_o,
    output logic             minus_o,
    output logic             halt_o
);
    // contacts start closed so no edge is seen at power-up
    logic p_q = 1'b1, m_q = 1'b1, h_q = 1'b1;
    always_ff @(posedge mclk_i) begin
        p_q <= $signed(pos_i) < PLUS_AT;
        m_q <= $signed(pos_i) > MINUS_AT;
        h_q <= !press_i;
    end
    assign plus_o  = p_q;
    assign minus_o = m_q;
    assign halt_o  = h_q;
endmodule : travel_sensor_model
`default_nettype wire

// file: dv/travel_limit_estop_guard_tb_top.sv
// self-checking bench: wishbone tasks, position stimulus, soft-zone model
// assumes the sensor model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module travel_limit_estop_guard_tb_top;
    import travel_guard_pkg::*;
    logic              mclk_i = 1'b0, rst_i = 1'b1, press = 1'b0;
    logic              cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [ADDR_W-1:0] adr = '0;
    logic [3:0]        sel = '0;
    logic [DATA_W-1:0] wdat = '0, dat_o, q;
    logic [POS_W-1:0]  act = '0, perr = '0;
    logic ack_o, plus_c, minus_c, halt_c, soft_o, hard_o, alarm_o;
    logic pind_o, mind_o, servo_o, brake_o, alp_o, alm_o;
    int   err_count = 0, compares = 0, plim, mlim, mside = 0, scale = 0;
    int   exp_q[$];
    travel_limit_estop_guard dut (.mclk_i(mclk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .actual_pos_i(act),
        .pos_error_i(perr), .plus_travel_limit_i(plus_c),
        .minus_travel_limit_i(minus_c), .emergency_halt_input_i(halt_c),
        .soft_travel_warning_o(soft_o), .hard_travel_warning_o(hard_o),
        .emergency_halt_alarm_o(alarm_o), .plus_entry_indicator_o(pind_o),
        .minus_entry_indicator_o(mind_o), .servo_enable_o(servo_o),
        .dynamic_brake_o(brake_o), .allow_plus_move_o(alp_o),
        .allow_minus_move_o(alm_o));
    travel_sensor_model #(.PLUS_AT(5000), .MINUS_AT(-5000)) sensors (
        .mclk_i(mclk_i), .pos_i(act), .press_i(press), .plus_o(plus_c),
        .minus_o(minus_c), .halt_o(halt_c));
    task automatic close_out;
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic ticks(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : ticks
    // one classic cycle; waits up to 20 cycles for ack, a timeout counts as an error
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= 4'hf;
        do begin
            @(posedge mclk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        if (n >= 20) chk(1'b0, 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    // set positions, let two edges pass, compare with the zone model
    task automatic soft_step(input int a, input int e, input bit en,
                             input bit ck_allow);
        int c;
        bit zone;
        c = a + e;
        exp_q.push_back(c);
        @(posedge mclk_i);
        act  <= a;
        perr <= e;
        ticks(2);
        zone = en && (c >= plim || c <= mlim);
        if (!zone) mside = 0;
        else if (mside == 0) mside = (c >= plim) ? 1 : 2;
        chk(soft_o, zone);
        chk(pind_o, scale ? mside == 2 : mside == 1);
        chk(mind_o, scale ? mside == 1 : mside == 2);
        if (ck_allow) chk({alp_o, alm_o}, {mside != 1, mside != 2});
        wb(1'b0, CMD_POS_OFS, '0);
        chk(q, exp_q.pop_front());
    endtask : soft_step
    initial begin
        forever #50 mclk_i = ~mclk_i;
    end
    initial begin
        ticks(30000);
        err_count++;
        close_out;
    end
    initial begin
        void'($urandom(32'h5237));
        ticks(12);
        rst_i <= 1'b0;
        ticks(10);
        wb(1'b0, CTRL_OFS, '0);
        chk(q, CTRL_RESET);
        wb(1'b0, PLUS_LIMIT_OFS, '0);
        chk(q, PLUS_LIMIT_RESET);
        wb(1'b0, MINUS_LIMIT_OFS, '0);
        chk(q, MINUS_LIMIT_RESET);
        wb(1'b1, 8'h20, 32'h1234);
        wb(1'b0, 8'h20, '0);
        chk(q, 32'h0);
        plim = 1000;
        mlim = -1000;
        wb(1'b1, PLUS_LIMIT_OFS, plim);
        wb(1'b1, MINUS_LIMIT_OFS, mlim);
        for (scale = 0; scale < 2; scale++) begin
            wb(1'b1, CTRL_OFS, 32'h3e | scale);
            soft_step(1200, -400, 1, 1);
            soft_step(800, 300, 1, 1);
            soft_step(0, 0, 1, 1);
            soft_step(-900, -200, 1, 1);
            soft_step(1500, 0, 1, 1);
            soft_step(-1500, 0, 1, 0);
            soft_step(0, 0, 1, 1);
        end
        scale = 0;
        wb(1'b1, CTRL_OFS, 32'h3e);
        repeat (16) begin
            soft_step($urandom_range(3000) - 1500, $urandom_range(800) - 400,
                      1, 1);
            soft_step(0, 0, 1, 1);
        end
        // plus side with servo off, minus side with servo on
        for (int s = 0; s < 2; s++) begin
            wb(1'b1, CTRL_OFS, s ? 32'h3c : 32'h1c);
            soft_step(s ? -5200 : 5200, 0, 0, 0);
            ticks(8);
            chk(hard_o, 1'b1);
            wb(1'b0, STATUS_OFS, '0);
            chk(q[ST_HARD_MINUS:ST_HARD_PLUS], s ? 2'b10 : 2'b01);
            soft_step(s ? -5300 : 5300, 0, 0, 0);
            ticks(20);
            chk(hard_o, 1'b1);
            if (s) chk({alp_o, alm_o}, 2'b10);
            soft_step(s ? -4900 : 4900, 0, 0, 0);
            ticks(8);
            chk(hard_o, 1'b0);
        end
        wb(1'b1, CTRL_OFS, 32'h3e);
        ticks(2);
        chk({alarm_o, servo_o, brake_o}, 3'b010);
        press <= 1'b1;
        ticks(10);
        chk({alarm_o, servo_o, brake_o}, 3'b101);
        press <= 1'b0;
        ticks(10);
        chk({alarm_o, servo_o, brake_o}, 3'b010);
        wb(1'b1, CTRL_OFS, 32'h2e);
        ticks(10);
        chk(alarm_o, 1'b1);
        wb(1'b1, CTRL_OFS, 32'h3e);
        ticks(10);
        chk(alarm_o, 1'b0);
        close_out;
    end
endmodule : travel_limit_estop_guard_tb_top
`default_nettype wire
